// >>> design/acsu_top.sv
// Functional notes
// - Real load takes two adjacent words or a constant into the accumulator.
// - Real values are 32-bit single floats, always two words.
// - Negative flag follows the sign of a real load, except minus zero; word loads always clear it.
// - Zero-load flag is set when any load gives zero.
// - Word store writes accumulator low half to one word, direct or via pointer.
// - Double store writes all 32 bits to two adjacent words.
// - Bitfield store copies 1 to 32 accumulator bits to consecutive discrete bits.
// - Bitfield targets inputs/outputs up to 1777, relays up to 3777, count 1-32.
// - Indexed store writes stack level one low half to base plus accumulator.
// - Indexed offset is a plain binary quantity.
// - Indexed store clears the upper accumulator half.
// - Back-to-back loads push the first value onto the stack.
// - Low-byte store writes accumulator bits 7-0 to the word's low byte.
// - High-byte store writes accumulator bits 15-8 to the word's high byte.
// - Pop moves stack level one into the accumulator.
// - Pop shifts the remaining stack levels up by one.
// - Zero-result flag is set when a pop leaves zero.
`timescale 1ns/1ps
`default_nettype none
module acsu_top
  import acsu_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              cmd_valid_i,
  input  wire acsu_cmd_s         cmd_i,
  output logic                   cmd_ready_o,
  output logic                   done_o,
  output logic                   err_o,
  output logic [ACC_W-1:0]       acc_o,
  output acsu_flags_s            flags_o,
  output acsu_word_req_s         mem_o,
  input  wire logic              mem_ack_i,
  input  wire logic [WORD_W-1:0] mem_rdata_i,
  output acsu_bit_req_s          bit_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR,
    ST_RD,
    ST_WR,
    ST_BITS
  } acsu_state_e;

  typedef struct packed {
    acsu_state_e       st;
    acsu_cmd_s         cmd;
    logic [ACC_W-1:0]  acc;
    logic [ADDR_W-1:0] ea;
    logic              hi_word;
    logic [WORD_W-1:0] rd_lo;
    logic [CNT_W-1:0]  bit_pos;
    logic              last_load;
    logic              ready;
    logic              done;
    logic              err;
    acsu_word_req_s    wreq;
    acsu_bit_req_s     breq;
    acsu_flags_s       flags;
  } acsu_state_s;

  localparam acsu_state_s STATE_RST = '{
    st:      ST_IDLE,
    acc:     ACC_RST,
    ready:   1'b1,
    default: '0
  };

  acsu_state_s      s;
  acsu_state_s      next_s;
  logic [ACC_W-1:0] stack_top;
  logic             push;
  logic             pop;
  logic [ACC_W-1:0] ld_val;
  logic             ld_real;
  logic             ld_neg;
  logic             ld_zero;
  logic             is_load;
  logic             fmt_ok;
  logic [BIT_IDX_W:0] fmt_end;
  logic [BIT_IDX_W:0] fmt_last;

  acsu_stack u_stack (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (s.acc),
    .top_o       (stack_top)
  );

  acsu_load_flags u_load_flags (
    .value_i (ld_val),
    .real_i  (ld_real),
    .neg_o   (ld_neg),
    .zero_o  (ld_zero)
  );

  // Candidate load value, from constant at accept time or from memory data
  always_comb begin
    ld_real = 1'b0;
    ld_val  = ACC_RST;
    if (s.st == ST_IDLE) begin
      ld_real = (cmd_i.op == load_real_op);
      ld_val  = ld_real ? cmd_i.konst : {16'h0000, cmd_i.konst[WORD_W-1:0]};
    end else begin
      ld_real = (s.cmd.op == load_real_op);
      ld_val  = ld_real ? {mem_rdata_i, s.rd_lo}
                        : {16'h0000, mem_rdata_i};
    end
  end

  assign is_load = (cmd_i.op == load_word_op) || (cmd_i.op == load_real_op);

  // Bitfield destination check, done once at accept time
  always_comb begin
    fmt_last = {1'b0, (cmd_i.region == bit_relay) ? CR_BIT_LAST : IO_BIT_LAST};
    fmt_end  = {1'b0, cmd_i.addr[BIT_IDX_W-1:0]} + {6'h00, cmd_i.count} - 12'h001;
    fmt_ok   = (cmd_i.region != bit_none)
             && (cmd_i.addr[ADDR_W-1:BIT_IDX_W] == '0)
             && (cmd_i.count >= BITCNT_MIN) && (cmd_i.count <= BITCNT_MAX)
             && (fmt_end <= fmt_last)
             && !cmd_i.use_ptr && !cmd_i.use_const;
  end

  // First memory access once the effective base is known
  function automatic acsu_state_s start_mem(acsu_state_s c, logic [ADDR_W-1:0] base,
                                            logic [ACC_W-1:0] top);
    acsu_state_s r;
    r              = c;
    r.hi_word      = 1'b0;
    r.wreq.req     = 1'b1;
    r.wreq.we      = 1'b0;
    r.wreq.wdata   = '0;
    // Offset taken as unsigned binary, carry out dropped
    r.ea           = (c.cmd.op == store_indexed_op) ? base + c.acc[WORD_W-1:0]
                                                    : base;
    r.wreq.addr    = r.ea;
    r.st           = ST_RD;
    unique case (c.cmd.op)
      store_word_op: begin
        r.wreq.we    = 1'b1;
        r.wreq.wdata = c.acc[WORD_W-1:0];
        r.st         = ST_WR;
      end
      store_double_op: begin
        r.wreq.we    = 1'b1;
        r.wreq.wdata = c.acc[WORD_W-1:0];
        r.st         = ST_WR;
      end
      store_indexed_op: begin
        r.wreq.we    = 1'b1;
        r.wreq.wdata = top[WORD_W-1:0];
        r.st         = ST_WR;
      end
      // Loads and byte stores read first
      default: r.st  = ST_RD;
    endcase
    return r;
  endfunction

  function automatic acsu_state_s finish(acsu_state_s c);
    acsu_state_s r;
    r       = c;
    r.st    = ST_IDLE;
    r.ready = 1'b1;
    r.done  = 1'b1;
    return r;
  endfunction

  function automatic acsu_state_s reject(acsu_state_s c);
    acsu_state_s r;
    r       = finish(c);
    r.done  = 1'b0;
    r.err   = 1'b1;
    return r;
  endfunction

  always_comb begin
    next_s         = s;
    next_s.done    = 1'b0;
    next_s.err     = 1'b0;
    next_s.breq.we = 1'b0;
    push           = 1'b0;
    pop            = 1'b0;
    unique case (s.st)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          next_s.cmd       = cmd_i;
          next_s.ready     = 1'b0;
          next_s.bit_pos   = '0;
          next_s.hi_word   = 1'b0;
          next_s.last_load = is_load;
          // Old value saved before the new one lands
          push             = is_load && s.last_load;
          unique case (cmd_i.op)
            load_word_op, load_real_op: begin
              if (cmd_i.use_const) begin
                next_s.acc                  = ld_val;
                next_s.flags.negative_flag  = ld_neg;
                next_s.flags.zero_load_flag = ld_zero;
                next_s                      = finish(next_s);
              end else if (cmd_i.use_ptr) begin
                next_s.wreq = '{req: 1'b1, we: 1'b0, addr: cmd_i.addr, wdata: '0};
                next_s.st   = ST_PTR;
              end else begin
                next_s = start_mem(next_s, cmd_i.addr, stack_top);
              end
            end
            store_word_op, store_double_op, store_indexed_op: begin
              // A constant cannot be a destination
              if (cmd_i.use_const) begin
                next_s = reject(next_s);
              end else if (cmd_i.use_ptr) begin
                next_s.wreq = '{req: 1'b1, we: 1'b0, addr: cmd_i.addr, wdata: '0};
                next_s.st   = ST_PTR;
              end else begin
                next_s = start_mem(next_s, cmd_i.addr, stack_top);
              end
            end
            store_low_byte_op, store_high_byte_op: begin
              if (cmd_i.use_const || cmd_i.use_ptr) begin
                next_s = reject(next_s);
              end else begin
                next_s = start_mem(next_s, cmd_i.addr, stack_top);
              end
            end
            store_bitfield_op: begin
              if (fmt_ok) begin
                next_s.st = ST_BITS;
              end else begin
                next_s = reject(next_s);
              end
            end
            pop_op: begin
              pop                           = 1'b1;
              next_s.acc                    = stack_top;
              next_s.flags.zero_result_flag = (stack_top == '0);
              next_s                        = finish(next_s);
            end
            default: begin
              // Illegal opcodes fall here as well as the no-op
              next_s = finish(next_s);
            end
          endcase
        end
      end
      ST_PTR: begin
        if (mem_ack_i) begin
          next_s = start_mem(next_s, mem_rdata_i, stack_top);
        end
      end
      ST_RD: begin
        if (mem_ack_i) begin
          next_s.wreq.req = 1'b0;
          unique case (s.cmd.op)
            load_real_op: begin
              if (!s.hi_word) begin
                next_s.rd_lo     = mem_rdata_i;
                next_s.hi_word   = 1'b1;
                next_s.wreq.req  = 1'b1;
                next_s.wreq.addr = s.ea + NEXT_WORD;
              end else begin
                next_s.acc                  = ld_val;
                next_s.flags.negative_flag  = ld_neg;
                next_s.flags.zero_load_flag = ld_zero;
                next_s                      = finish(next_s);
              end
            end
            store_low_byte_op: begin
              next_s.wreq.req   = 1'b1;
              next_s.wreq.we    = 1'b1;
              next_s.wreq.wdata = {mem_rdata_i[WORD_W-1:HI_BYTE_LSB],
                                   s.acc[LO_BYTE_MSB:0]};
              next_s.st         = ST_WR;
            end
            store_high_byte_op: begin
              next_s.wreq.req   = 1'b1;
              next_s.wreq.we    = 1'b1;
              next_s.wreq.wdata = {s.acc[WORD_W-1:HI_BYTE_LSB],
                                   mem_rdata_i[LO_BYTE_MSB:0]};
              next_s.st         = ST_WR;
            end
            default: begin
              next_s.acc                  = ld_val;
              next_s.flags.negative_flag  = ld_neg;
              next_s.flags.zero_load_flag = ld_zero;
              next_s                      = finish(next_s);
            end
          endcase
        end
      end
      ST_WR: begin
        if (mem_ack_i) begin
          next_s.wreq.req = 1'b0;
          if (s.cmd.op == store_double_op && !s.hi_word) begin
            next_s.hi_word    = 1'b1;
            next_s.wreq.req   = 1'b1;
            next_s.wreq.addr  = s.ea + NEXT_WORD;
            next_s.wreq.wdata = s.acc[ACC_W-1:WORD_W];
          end else begin
            if (s.cmd.op == store_indexed_op) begin
              next_s.acc[ACC_W-1:WORD_W] = '0;
            end
            next_s = finish(next_s);
          end
        end
      end
      ST_BITS: begin
        // One discrete bit per cycle, lowest accumulator bit first
        next_s.breq.we     = 1'b1;
        next_s.breq.region = s.cmd.region;
        next_s.breq.idx    = s.cmd.addr[BIT_IDX_W-1:0] + {5'h00, s.bit_pos};
        next_s.breq.data   = s.acc[s.bit_pos[4:0]];
        next_s.bit_pos     = s.bit_pos + 6'h01;
        if (s.bit_pos + 6'h01 == s.cmd.count) begin
          next_s = finish(next_s);
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_ready_o = s.ready;
  assign done_o      = s.done;
  assign err_o       = s.err;
  assign acc_o       = s.acc;
  assign flags_o     = s.flags;
  assign mem_o       = s.wreq;
  assign bit_o       = s.breq;

endmodule
`default_nettype wire

// >>> pkg/acsu_pkg.sv
`default_nettype none
package acsu_pkg;

  localparam int ACC_W       = 32;
  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 16;
  localparam int BIT_IDX_W   = 11;
  localparam int CNT_W       = 6;
  localparam int STACK_DEPTH = 8;

  // Accumulator and stack contents after reset
  localparam logic [ACC_W-1:0]     ACC_RST      = 32'h0000_0000;
  // Vacated stack level after a pop
  localparam logic [ACC_W-1:0]     STACK_FILL   = 32'h0000_0000;
  // Second word of a pair sits at the next address
  localparam logic [ADDR_W-1:0]    NEXT_WORD    = 16'h0001;
  // Last bit index: octal 1777 for inputs and outputs, octal 3777 for relays
  localparam logic [BIT_IDX_W-1:0] IO_BIT_LAST  = 11'h3ff;
  localparam logic [BIT_IDX_W-1:0] CR_BIT_LAST  = 11'h7ff;
  localparam logic [CNT_W-1:0]     BITCNT_MIN   = 6'h01;
  localparam logic [CNT_W-1:0]     BITCNT_MAX   = 6'h20;
  // Field positions inside the accumulator
  localparam int                   SIGN_BIT     = 31;
  localparam int                   LO_BYTE_MSB  = 7;
  localparam int                   HI_BYTE_LSB  = 8;

  typedef enum logic [3:0] {
    nop_op,
    load_word_op,
    load_real_op,
    store_word_op,
    store_double_op,
    store_bitfield_op,
    store_indexed_op,
    store_low_byte_op,
    store_high_byte_op,
    pop_op
  } acsu_op_e;

  typedef enum logic [1:0] {
    bit_input,
    bit_output,
    bit_relay,
    bit_none
  } acsu_bit_region_e;

  typedef struct packed {
    acsu_op_e            op;
    logic                use_const;
    logic                use_ptr;
    logic [ADDR_W-1:0]   addr;
    logic [ACC_W-1:0]    konst;
    acsu_bit_region_e    region;
    logic [CNT_W-1:0]    count;
  } acsu_cmd_s;

  typedef struct packed {
    logic                req;
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   wdata;
  } acsu_word_req_s;

  typedef struct packed {
    logic                we;
    acsu_bit_region_e    region;
    logic [BIT_IDX_W-1:0] idx;
    logic                data;
  } acsu_bit_req_s;

  typedef struct packed {
    logic                negative_flag;
    logic                zero_load_flag;
    logic                zero_result_flag;
  } acsu_flags_s;

endpackage
`default_nettype wire

// >>> design/acsu_load_flags.sv
`timescale 1ns/1ps
`default_nettype none
module acsu_load_flags
  import acsu_pkg::*;
(
  input  wire logic [ACC_W-1:0] value_i,
  input  wire logic             real_i,
  output logic                  neg_o,
  output logic                  zero_o
);

  logic mag_zero;

  // Real minus zero counts as zero, never as negative
  assign mag_zero = (value_i[ACC_W-2:0] == '0);
  assign zero_o   = real_i ? mag_zero : (value_i == '0);
  assign neg_o    = value_i[SIGN_BIT] & ~(real_i & mag_zero);

endmodule
`default_nettype wire

// >>> design/acsu_stack.sv
`timescale 1ns/1ps
`default_nettype none
module acsu_stack
  import acsu_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [ACC_W-1:0] push_data_i,
  output logic      [ACC_W-1:0] top_o
);

  typedef struct packed {
    logic [STACK_DEPTH-1:0][ACC_W-1:0] lvl;
  } acsu_stack_s;

  acsu_stack_s s;
  acsu_stack_s next_s;

  always_comb begin
    next_s = s;
    if (push_i) begin
      // Bottom level falls off when full
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        next_s.lvl[i] = s.lvl[i-1];
      end
      next_s.lvl[0] = push_data_i;
    end else if (pop_i) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        next_s.lvl[i] = s.lvl[i+1];
      end
      next_s.lvl[STACK_DEPTH-1] = STACK_FILL;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '{lvl: '{default: ACC_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign top_o = s.lvl[0];

endmodule
`default_nettype wire

// >>> verif/acsu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module acsu_mem_model
  import acsu_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           slow_i,
  input  wire acsu_word_req_s mem_i,
  input  wire acsu_bit_req_s  bit_i,
  output logic                ack_o,
  output logic [WORD_W-1:0]   rdata_o
);
  logic [WORD_W-1:0] words [0:255];
  logic              bits  [0:3][0:2047];
  logic              ph = 1'h0;
  // Slow mode acks every other cycle, so held requests get exercised
  assign ack_o = mem_i.req && (!slow_i || ph);
  // Inverted data outside an ack, so a stray sample never matches
  assign rdata_o = ack_o ? words[mem_i.addr[7:0]] : ~words[mem_i.addr[7:0]];
  always @(posedge mclk_i) begin
    ph <= !ph;
    if (ack_o && mem_i.we) begin
      words[mem_i.addr[7:0]] <= mem_i.wdata;
    end
    if (bit_i.we) begin
      bits[bit_i.region][bit_i.idx] <= bit_i.data;
    end
  end
endmodule
`default_nettype wire

// >>> verif/acsu_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acsu_top_chk
  import acsu_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             cmd_valid_i,
  input  wire acsu_cmd_s        cmd_i,
  input  wire logic             cmd_ready_o,
  input  wire logic             done_o,
  input  wire logic             err_o,
  input  wire logic [ACC_W-1:0] acc_o,
  input  wire acsu_flags_s      flags_o,
  input  wire acsu_word_req_s   mem_o,
  input  wire logic             mem_ack_i,
  input  wire acsu_bit_req_s    bit_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire logic take = cmd_valid_i && cmd_ready_o;
  wire logic kld  = take && cmd_i.op == load_real_op && cmd_i.use_const;
  wire logic dir  = take && !cmd_i.use_const && !cmd_i.use_ptr;

  a_const_load: assert property (kld |=> done_o && acc_o == $past(cmd_i.konst))
    else $error("constant load value wrong");
  a_neg_flag: assert property (kld |=> flags_o.negative_flag ==
    ($past(cmd_i.konst[31]) && $past(cmd_i.konst[30:0]) != 31'h0))
    else $error("negative flag wrong");
  a_zero_load: assert property (kld |=>
    flags_o.zero_load_flag == ($past(cmd_i.konst[30:0]) == 31'h0))
    else $error("zero load flag wrong");
  a_word_store: assert property (dir && cmd_i.op == store_word_op |=> mem_o.req && mem_o.we
    && mem_o.addr == $past(cmd_i.addr) && mem_o.wdata == $past(acc_o[15:0]))
    else $error("word store request wrong");
  a_double_first: assert property (dir && cmd_i.op == store_double_op |=> mem_o.req
    && mem_o.we && mem_o.addr == $past(cmd_i.addr) && mem_o.wdata == $past(acc_o[15:0]))
    else $error("double store low half wrong");
  a_req_hold: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
    else $error("memory request dropped before ack");
  a_bit_count: assert property (take && cmd_i.op == store_bitfield_op
    && (cmd_i.count == 6'h0 || cmd_i.count > 6'h20) |=> err_o && !bit_o.we)
    else $error("bad bit count not refused");
  a_byte_direct: assert property (take && cmd_i.use_ptr && (cmd_i.op == store_low_byte_op
    || cmd_i.op == store_high_byte_op) |=> err_o && !mem_o.req)
    else $error("byte store via pointer not refused");
  a_pop_zero: assert property (take && cmd_i.op == pop_op |=> done_o
    && flags_o.zero_result_flag == (acc_o == 32'h0))
    else $error("pop zero flag wrong");
  a_acc_on_done: assert property ($changed(acc_o) |-> done_o)
    else $error("accumulator changed without completion");

  c_pop: cover property (take && cmd_i.op == pop_op);
  c_bits: cover property (bit_o.we);
  c_refuse: cover property (err_o);
endmodule
bind acsu_top acsu_top_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .err_o(err_o), .acc_o(acc_o),
  .flags_o(flags_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i), .bit_o(bit_o));
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
  import acsu_pkg::*;
  logic              mclk = 1'h0;
  logic              rst = 1'h1;
  logic              cmd_valid = 1'h0;
  acsu_cmd_s         cmd = '0;
  logic              slow = 1'h0;
  logic              ready, done, err, ack, er;
  logic [WORD_W-1:0] rdata;
  logic [ACC_W-1:0]  acc;
  acsu_flags_s       flags;
  acsu_word_req_s    mreq;
  acsu_bit_req_s     breq;
  int                fails = 0;
  int                check_count = 0;

  always #12.5 mclk = ~mclk;

  acsu_top dut_u (.mclk_i(mclk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(ready), .done_o(done), .err_o(err), .acc_o(acc), .flags_o(flags),
    .mem_o(mreq), .mem_ack_i(ack), .mem_rdata_i(rdata), .bit_o(breq));
  acsu_mem_model mem_u (.mclk_i(mclk), .slow_i(slow), .mem_i(mreq), .bit_i(breq),
    .ack_o(ack), .rdata_o(rdata));

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One command, offered for a single cycle, then a bounded wait for its answer
  task automatic run(input acsu_op_e op, input logic uc, input logic up, input logic [15:0] a,
                     input logic [31:0] k, input logic [5:0] n = 6'h0,
                     input acsu_bit_region_e rg = bit_input);
    int i;
    @(posedge mclk);
    cmd_valid <= 1'h1;
    cmd <= '{op, uc, up, a, k, rg, n};
    @(posedge mclk);
    cmd_valid <= 1'h0;
    for (i = 0; i < 100; i++) begin
      @(negedge mclk);
      if (done === 1'h1 || err === 1'h1) break;
    end
    er = err;
    if (i == 100) begin
      fails++;
      $display("ERROR %0t: no completion", $time);
    end
  endtask

  task automatic t_load_const();
    logic [31:0] tv [4] = '{32'hbf80_0000, 32'h0, 32'h8000_0000, 32'h4049_0fdb};
    foreach (tv[j]) begin
      run(load_real_op, 1'h1, 1'h0, 16'h0, tv[j]);
      `CHK(acc, tv[j])
      `CHK(flags.negative_flag, tv[j][31] && tv[j][30:0] != 31'h0)
      `CHK(flags.zero_load_flag, tv[j][30:0] == 31'h0)
    end
  endtask

  task automatic t_load_mem();
    slow <= 1'h1;
    mem_u.words[8'h10] = 16'h0000;
    mem_u.words[8'h11] = 16'hc2f6;
    mem_u.words[8'h20] = 16'h0012;
    mem_u.words[8'h12] = 16'h0000;
    mem_u.words[8'h13] = 16'h0000;
    run(load_real_op, 1'h0, 1'h0, 16'h10, 32'h0);
    `CHK(acc, 32'hc2f6_0000)
    `CHK(flags.negative_flag, 1'h1)
    run(load_real_op, 1'h0, 1'h1, 16'h20, 32'h0);
    `CHK(acc, 32'h0)
    `CHK(flags.zero_load_flag, 1'h1)
    // Word load from memory: one read, upper half cleared
    run(load_word_op, 1'h0, 1'h0, 16'h11, 32'h0);
    `CHK(acc, 32'h0000_c2f6)
    `CHK(flags.negative_flag, 1'h0)
    `CHK(flags.zero_load_flag, 1'h0)
  endtask

  task automatic t_store();
    slow <= 1'h0;
    run(load_real_op, 1'h1, 1'h0, 16'h0, 32'h1234_5678);
    mem_u.words[8'h21] = 16'h0031;
    mem_u.words[8'h50] = 16'haaaa;
    mem_u.words[8'h51] = 16'h5555;
    run(store_word_op, 1'h0, 1'h0, 16'h30, 32'h0);
    `CHK(mem_u.words[8'h30], 16'h5678)
    run(store_word_op, 1'h0, 1'h1, 16'h21, 32'h0);
    `CHK(mem_u.words[8'h31], 16'h5678)
    slow <= 1'h1;
    run(store_double_op, 1'h0, 1'h0, 16'h40, 32'h0);
    `CHK({mem_u.words[8'h41], mem_u.words[8'h40]}, 32'h1234_5678)
    run(store_low_byte_op, 1'h0, 1'h0, 16'h50, 32'h0);
    `CHK(mem_u.words[8'h50], 16'haa78)
    run(store_high_byte_op, 1'h0, 1'h0, 16'h51, 32'h0);
    `CHK(mem_u.words[8'h51], 16'h5655)
    run(store_low_byte_op, 1'h0, 1'h1, 16'h52, 32'h0);
    `CHK(er, 1'h1)
    `CHK(acc, 32'h1234_5678)
  endtask

  task automatic t_bitfield();
    logic [31:0]      v = 32'h1234_5678;
    logic [15:0]      ra [4] = '{16'h3e0, 16'h3e0, 16'h7ff, 16'h3ff};
    logic [5:0]       rn [4] = '{6'h0, 6'h21, 6'h2, 6'h2};
    acsu_bit_region_e rr [4] = '{bit_output, bit_output, bit_relay, bit_input};
    run(store_bitfield_op, 1'h0, 1'h0, 16'h3e0, 32'h0, 6'h20, bit_output);
    // Last bit stands with done, so the partner stores it one edge later
    @(negedge mclk);
    for (int i = 0; i < 32; i++) `CHK(mem_u.bits[bit_output][11'h3e0 + i], v[i])
    run(store_bitfield_op, 1'h0, 1'h0, 16'h7ff, 32'h0, 6'h1, bit_relay);
    @(negedge mclk);
    `CHK(er, 1'h0)
    `CHK(mem_u.bits[bit_relay][11'h7ff], v[0])
    // Entries break: count low, count high plus output end, relay end, input end
    foreach (ra[j]) begin
      run(store_bitfield_op, 1'h0, 1'h0, ra[j], 32'h0, rn[j], rr[j]);
      `CHK(er, 1'h1)
    end
  endtask

  task automatic t_stack();
    logic [31:0] pv [3] = '{32'h0, 32'h1111_1111, 32'h0};
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    run(load_real_op, 1'h1, 1'h0, 16'h0, 32'h1111_1111);
    run(load_real_op, 1'h1, 1'h0, 16'h0, 32'h0);
    run(load_real_op, 1'h1, 1'h0, 16'h0, 32'h3333_3333);
    foreach (pv[j]) begin
      run(pop_op, 1'h0, 1'h0, 16'h0, 32'h0);
      `CHK(acc, pv[j])
      `CHK(flags.zero_result_flag, pv[j] == 32'h0)
    end
  endtask

  task automatic t_indexed();
    run(load_word_op, 1'h1, 1'h0, 16'h0, 32'hffff_0abc);
    `CHK(acc, 32'h0000_0abc)
    run(load_real_op, 1'h1, 1'h0, 16'h0, 32'hffff_0005);
    run(store_indexed_op, 1'h0, 1'h0, 16'h60, 32'h0);
    `CHK(mem_u.words[8'h65], 16'h0abc)
    `CHK(acc, 32'h0000_0005)
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    t_load_const();
    t_load_mem();
    t_store();
    t_bitfield();
    t_stack();
    t_indexed();
    finish_test();
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
